// [rtl/acs_sequencer.sv]
// Purpose: conversion timing and analog front-end control
// Assumes: commands arrive as one-cycle pulses from the command port
// Notes: configuration ports are on the system clock, no synchronisers
`timescale 1ns/100ps
`include "acs_params.svh"
module acs_sequencer
(
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // commands from the serial command port
    input wire logic start_cmd,
    input wire logic sleep_cmd,
    input wire logic result_read,
    // conversion configuration
    input wire logic continuous_mode,
    input wire logic turbo_mode,
    input wire acs_pkg::acs_rate_t rate_select,
    // excitation configuration
    input wire acs_pkg::acs_field3_t excitation_magnitude,
    input wire acs_pkg::acs_field3_t excitation_one_route,
    input wire acs_pkg::acs_field3_t excitation_two_route,
    input wire logic burnout_enable,
    // input and reference configuration
    input wire acs_pkg::acs_sel_t input_selector,
    input wire acs_pkg::acs_field3_t gain_select,
    input wire logic amp_bypass,
    input wire logic [1:0] reference_select,
    // conversion status
    output logic result_ready_n,
    output logic conversion_done,
    output logic converting,
    output logic sleeping,
    output logic mod_clock_tick,
    // filter control
    output logic filter_restart,
    output acs_pkg::acs_rate_t filter_rate,
    // excitation control
    output logic excitation_bias_en,
    output acs_pkg::acs_field3_t excitation_level,
    output logic excitation_one_en,
    output acs_pkg::acs_field3_t excitation_one_pin,
    output logic excitation_two_en,
    output acs_pkg::acs_field3_t excitation_two_pin,
    output logic burnout_source_en,
    output logic burnout_sink_en,
    // front-end control
    output logic amp_bypassed,
    output acs_pkg::acs_field3_t effective_gain,
    output logic internal_ref_en,
    output logic supply_monitor_en,
    output logic refin_monitor_en
);
    import acs_pkg::*;

    acs_state_t state_reg;
    acs_state_t start_state;
    acs_cnt_t cnt_reg;
    acs_cnt_t start_cnt;
    logic cont_run_reg;
    logic sleep_pend_reg;
    logic half_tick;
    logic mod_tick;
    logic last_half;
    logic conv_end;
    logic monitor_sel;
    logic powered;

    acs_tick_gen u_tick
    (
        .clock(clock),
        .rst(rst),
        .turbo_mode(turbo_mode),
        .half_tick(half_tick),
        .conv_tick(),
        .mod_tick(mod_tick)
    );

    // continuous period in half conversion periods, either clock mode
    function automatic acs_cnt_t cont_period(input acs_rate_t rate);
        logic [15:0] v;
        v = `ACS_CONT_R6;
        case (rate)
            3'h0: v = `ACS_CONT_R0;
            3'h1: v = `ACS_CONT_R1;
            3'h2: v = `ACS_CONT_R2;
            3'h3: v = `ACS_CONT_R3;
            3'h4: v = `ACS_CONT_R4;
            3'h5: v = `ACS_CONT_R5;
            default: v = `ACS_CONT_R6;
        endcase
        return {v, 1'b0};
    endfunction

    // single-shot time, start-up delay already included
    function automatic acs_cnt_t single_time(input acs_rate_t rate,
                                             input logic turbo);
        logic [15:0] v;
        v = `ACS_SNGL_N6;
        case ({turbo, rate})
            4'h0: v = `ACS_SNGL_N0;
            4'h1: v = `ACS_SNGL_N1;
            4'h2: v = `ACS_SNGL_N2;
            4'h3: v = `ACS_SNGL_N3;
            4'h4: v = `ACS_SNGL_N4;
            4'h5: v = `ACS_SNGL_N5;
            4'h6: v = `ACS_SNGL_N6;
            4'h7: v = `ACS_SNGL_N6;
            4'h8: v = `ACS_SNGL_T0;
            4'h9: v = `ACS_SNGL_T1;
            4'hA: v = `ACS_SNGL_T2;
            4'hB: v = `ACS_SNGL_T3;
            4'hC: v = `ACS_SNGL_T4;
            4'hD: v = `ACS_SNGL_T5;
            default: v = `ACS_SNGL_T6;
        endcase
        return {v, 1'b0};
    endfunction

    assign last_half = half_tick && (cnt_reg == 17'h00001);
    assign conv_end = (state_reg == ACS_CONV) && last_half;
    assign monitor_sel = (input_selector == `ACS_MUX_REF_MON) ||
                         (input_selector == `ACS_MUX_SUP_MON);
    assign powered = (state_reg != ACS_SLEEP);

    // start pulse is the command latch point; its baud-dependent offset
    // from the stop bit is settled in the command port
    always_comb
    begin
        start_state = ACS_CONV;
        start_cnt = single_time(rate_select, turbo_mode);
        if (continuous_mode)
        begin
            start_state = ACS_DELAY;
            start_cnt = turbo_mode ? `ACS_START_TURBO_X2 :
                                     `ACS_START_NORMAL_X2;
        end
    end

    // a new start always wins: it resynchronises a running sequence
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            state_reg <= ACS_IDLE;
            cnt_reg <= 17'h00000;
        end
        else if (start_cmd)
        begin
            state_reg <= start_state;
            cnt_reg <= start_cnt;
        end
        else
        begin
            case (state_reg)
                ACS_IDLE:
                begin
                    if (sleep_cmd)
                        state_reg <= ACS_SLEEP;
                end
                ACS_DELAY:
                begin
                    if (last_half)
                    begin
                        // delay paid once, then only whole periods
                        state_reg <= ACS_CONV;
                        cnt_reg <= cont_period(rate_select);
                    end
                    else if (half_tick)
                        cnt_reg <= cnt_reg - 17'h00001;
                end
                ACS_CONV:
                begin
                    if (last_half)
                    begin
                        if (sleep_pend_reg || sleep_cmd)
                            state_reg <= ACS_SLEEP;
                        else if (cont_run_reg)
                            cnt_reg <= cont_period(rate_select);
                        else
                            state_reg <= ACS_IDLE;
                    end
                    else if (half_tick)
                        cnt_reg <= cnt_reg - 17'h00001;
                end
                ACS_SLEEP:
                    state_reg <= ACS_SLEEP;
                default:
                    state_reg <= ACS_IDLE;
            endcase
        end
    end

    always_ff @(posedge clock)
    begin
        if (rst)
            cont_run_reg <= 1'b0;
        else if (start_cmd)
            cont_run_reg <= continuous_mode;
    end

    // sleep lets the running conversion finish; a set beats the clear
    always_ff @(posedge clock)
    begin
        if (rst)
            sleep_pend_reg <= 1'b0;
        else if (sleep_cmd && (state_reg != ACS_IDLE))
            sleep_pend_reg <= 1'b1;
        else if (start_cmd || (state_reg == ACS_SLEEP))
            sleep_pend_reg <= 1'b0;
    end

    // a new result pulls the line low even if read in the same cycle;
    // in continuous runs a one-half-period high pulse keeps every
    // completion visible as its own falling edge
    always_ff @(posedge clock)
    begin
        if (rst)
            result_ready_n <= 1'b1;
        else if (conv_end)
            result_ready_n <= 1'b0;
        else if (start_cmd || result_read)
            result_ready_n <= 1'b1;
        else if ((state_reg == ACS_CONV) && half_tick && cont_run_reg &&
                 (cnt_reg == 17'h00002))
            result_ready_n <= 1'b1;
    end

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            conversion_done <= 1'b0;
            converting <= 1'b0;
            sleeping <= 1'b0;
            mod_clock_tick <= 1'b0;
        end
        else
        begin
            conversion_done <= conv_end;
            converting <= (state_reg == ACS_DELAY) ||
                          (state_reg == ACS_CONV);
            sleeping <= (state_reg == ACS_SLEEP);
            mod_clock_tick <= mod_tick && converting;
        end
    end

    // filter restarts with each start and follows the chosen rate, so
    // the first period already yields a settled result
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            filter_restart <= 1'b0;
            filter_rate <= 3'h0;
        end
        else
        begin
            filter_restart <= start_cmd;
            if (start_cmd)
                filter_rate <= rate_select;
        end
    end

    // excitation tracks the fields live; host orders the writes so the
    // bias settles before any routing is applied
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            excitation_bias_en <= 1'b0;
            excitation_level <= `ACS_MAG_OFF;
            excitation_one_en <= 1'b0;
            excitation_one_pin <= `ACS_ROUTE_OFF;
            excitation_two_en <= 1'b0;
            excitation_two_pin <= `ACS_ROUTE_OFF;
        end
        else
        begin
            excitation_bias_en <= powered &&
                (excitation_magnitude != `ACS_MAG_OFF);
            excitation_level <= excitation_magnitude;
            excitation_one_en <= powered &&
                (excitation_magnitude != `ACS_MAG_OFF) &&
                (excitation_one_route != `ACS_ROUTE_OFF);
            excitation_two_en <= powered &&
                (excitation_magnitude != `ACS_MAG_OFF) &&
                (excitation_two_route != `ACS_ROUTE_OFF);
            excitation_one_pin <= excitation_one_route;
            excitation_two_pin <= excitation_two_route;
        end
    end

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            burnout_source_en <= 1'b0;
            burnout_sink_en <= 1'b0;
        end
        else
        begin
            burnout_source_en <= powered && burnout_enable;
            burnout_sink_en <= powered && burnout_enable;
        end
    end

    // monitor readings are coarse, so gain and reference are overridden
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            amp_bypassed <= 1'b0;
            effective_gain <= `ACS_GAIN_ONE;
            internal_ref_en <= 1'b1;
            supply_monitor_en <= 1'b0;
            refin_monitor_en <= 1'b0;
        end
        else
        begin
            amp_bypassed <= monitor_sel || amp_bypass;
            effective_gain <= monitor_sel ? `ACS_GAIN_ONE :
                                            gain_select;
            internal_ref_en <= monitor_sel ||
                (reference_select == `ACS_REF_INTERNAL);
            supply_monitor_en <=
                (input_selector == `ACS_MUX_SUP_MON);
            refin_monitor_en <=
                (input_selector == `ACS_MUX_REF_MON);
        end
    end

    default clocking acs_cb @(posedge clock);
    endclocking
    default disable iff (rst);

    chk_result_ready_n_fall_cause: assert property (
        $fell(result_ready_n) |-> $past(conv_end))
        else $error("result ready fell without a completed conversion");
    chk_start_delay: assert property (
        start_cmd && continuous_mode |=> (state_reg == ACS_DELAY) &&
        (cnt_reg == (turbo_mode ? 17'd210 : 17'd57)))
        else $error("start-up delay loaded wrongly");
    chk_single_load: assert property (
        start_cmd && !continuous_mode && turbo_mode &&
        (rate_select == 3'h0) |=> (cnt_reg == 17'd102434))
        else $error("single-shot time loaded wrongly");
    chk_cont_reload: assert property (
        conv_end && cont_run_reg && !start_cmd && !sleep_cmd &&
        !sleep_pend_reg && (rate_select == 3'h6) |=>
        (state_reg == ACS_CONV) && (cnt_reg == 17'd2072))
        else $error("continuous period reloaded wrongly");
    chk_result_ready_n_release: assert property (
        result_read && !conv_end |=> result_ready_n)
        else $error("result ready not released by read");
    chk_sleep_bias: assert property (
        (state_reg == ACS_SLEEP) |=> !excitation_bias_en &&
        !excitation_one_en && !excitation_two_en)
        else $error("excitation left on in sleep");
    chk_route_bias: assert property (
        excitation_one_en || excitation_two_en |-> excitation_bias_en)
        else $error("current routed without bias");
    chk_monitor_gain: assert property (
        monitor_sel |=> amp_bypassed && (effective_gain == `ACS_GAIN_ONE) &&
        internal_ref_en)
        else $error("monitor did not force unity gain");
    chk_delay_once: assert property (
        (state_reg == ACS_CONV) && !start_cmd |=> (state_reg != ACS_DELAY))
        else $error("start-up delay repeated");

    cov_single_done: cover property (@(posedge clock) disable iff (rst)
        conv_end && !cont_run_reg);
    cov_cont_two: cover property (@(posedge clock) disable iff (rst)
        $fell(result_ready_n) && cont_run_reg && (state_reg == ACS_CONV));
    cov_sleep_entry: cover property (@(posedge clock) disable iff (rst)
        conv_end && sleep_pend_reg);
    cov_monitor: cover property (@(posedge clock) disable iff (rst)
        supply_monitor_en && excitation_bias_en);
endmodule

// [rtl/acs_params.svh]
// Purpose: timing and field constants of the conversion sequencer
// Assumes: 125 MHz system clock, rate counts in conversion clock periods, start-up delays in half periods
// Notes: Operation list below; counter runs in half conversion periods
//
// Operation
// - filter adapts to rate and settles in the first conversion period
// - continuous period spans falling edge to falling edge of result ready
// - first conversion 28.5 periods normal, 105 turbo, after start latch
// - single-shot time runs from start latch to result ready falling edge
// - continuous periods 51192 down to 1036 cycles, same in both modes
// - single-shot times 51213..1061 normal, 51217..1065 turbo cycles
// - start-up delay applies once, ahead of the first result only
// - conversion clock is 1.024 MHz normal, 2.048 MHz turbo
// - command latch moment depends on baud rate, set by the command port
// - three-bit magnitude sets both excitation sources, seven settings
// - each source routes to any input or reference pin, same pin allowed
// - excitation stays up between single shots, off on sleep command
// - nonzero magnitude enables bias; current flows only when routed
// - burn-out sources drive positive input and sink negative input
// - monitor selection forces amplifier bypass and unity gain
// - code 1101 measures quarter supply on internal reference
// - code 1100 measures quarter external reference on internal reference
// - modulator clock is one quarter of the conversion clock
`ifndef ACS_PARAMS_SVH
`define ACS_PARAMS_SVH

`define ACS_SYS_CLK_HZ 125000000
`define ACS_CLK_NORMAL_HZ 1024000
`define ACS_CLK_TURBO_HZ 2048000
// accumulator step for ticks at twice the conversion clock
`define ACS_STEP_NORMAL \
    32'(((64'(`ACS_CLK_NORMAL_HZ) * 64'h2) << 32) / 64'(`ACS_SYS_CLK_HZ))
`define ACS_STEP_TURBO \
    32'(((64'(`ACS_CLK_TURBO_HZ) * 64'h2) << 32) / 64'(`ACS_SYS_CLK_HZ))
`define ACS_HALF_PER_MOD 3'h7

// start-up delay in half conversion periods (28.5 and 105 periods)
`define ACS_START_NORMAL_X2 17'h00039
`define ACS_START_TURBO_X2 17'h000D2

`define ACS_CONT_R0 16'd51192
`define ACS_CONT_R1 16'd22780
`define ACS_CONT_R2 16'd11532
`define ACS_CONT_R3 16'd5916
`define ACS_CONT_R4 16'd3116
`define ACS_CONT_R5 16'd1724
`define ACS_CONT_R6 16'd1036

`define ACS_SNGL_N0 16'd51213
`define ACS_SNGL_N1 16'd22805
`define ACS_SNGL_N2 16'd11557
`define ACS_SNGL_N3 16'd5941
`define ACS_SNGL_N4 16'd3141
`define ACS_SNGL_N5 16'd1749
`define ACS_SNGL_N6 16'd1061
`define ACS_SNGL_T0 16'd51217
`define ACS_SNGL_T1 16'd22809
`define ACS_SNGL_T2 16'd11561
`define ACS_SNGL_T3 16'd5945
`define ACS_SNGL_T4 16'd3145
`define ACS_SNGL_T5 16'd1753
`define ACS_SNGL_T6 16'd1065

`define ACS_MUX_REF_MON 4'hC
`define ACS_MUX_SUP_MON 4'hD
`define ACS_REF_INTERNAL 2'h0
`define ACS_GAIN_ONE 3'h0
`define ACS_MAG_OFF 3'h0
`define ACS_ROUTE_OFF 3'h0

`endif

// [rtl/acs_pkg.sv]
// Purpose: shared types of the conversion sequencer
// Assumes: constants live in acs_params.svh
// Notes: none
package acs_pkg;
    typedef logic [2:0] acs_rate_t;
    typedef logic [2:0] acs_field3_t;
    typedef logic [3:0] acs_sel_t;
    typedef logic [16:0] acs_cnt_t;
    typedef enum logic [1:0] {
        ACS_IDLE = 2'b00,
        ACS_DELAY = 2'b01,
        ACS_CONV = 2'b10,
        ACS_SLEEP = 2'b11
    } acs_state_t;
endpackage

// [rtl/acs_tick_gen.sv]
// Purpose: conversion and modulator clock ticks from the system clock
// Assumes: 125 MHz clock, fractional accumulator
// Notes: ticks jitter by one system cycle; average rate is set by the truncated accumulator step
`timescale 1ns/100ps
`include "acs_params.svh"
module acs_tick_gen
(
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // mode
    input wire logic turbo_mode,
    // ticks
    output logic half_tick,
    output logic conv_tick,
    output logic mod_tick
);
    logic [31:0] acc_reg;
    logic [32:0] acc_sum;
    logic [2:0] phase_reg;

    // a 33-bit sum keeps the carry that marks each half period
    assign acc_sum = {1'b0, acc_reg} + {1'b0, (turbo_mode ?
        `ACS_STEP_TURBO : `ACS_STEP_NORMAL)};

    always_ff @(posedge clock)
    begin
        if (rst)
            acc_reg <= 32'h0;
        else
            acc_reg <= acc_sum[31:0];
    end

    always_ff @(posedge clock)
    begin
        if (rst)
            phase_reg <= 3'h0;
        else if (acc_sum[32])
            phase_reg <= phase_reg + 3'h1;
    end

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            half_tick <= 1'b0;
            conv_tick <= 1'b0;
            mod_tick <= 1'b0;
        end
        else
        begin
            half_tick <= acc_sum[32];
            conv_tick <= acc_sum[32] & phase_reg[0];
            // every eighth half period: a quarter of the conversion clock
            mod_tick <= acc_sum[32] & (phase_reg == `ACS_HALF_PER_MOD);
        end
    end

    chk_half_spacing: assert property (
        @(posedge clock) disable iff (rst)
        half_tick |=> !half_tick [*8])
        else $error("half period ticks too close");
    chk_mod_quarter: assert property (
        @(posedge clock) disable iff (rst)
        mod_tick |-> conv_tick && half_tick)
        else $error("modulator tick off the conversion clock");
endmodule

// [verif/acs_host_model.sv]
// Purpose: host model that reads each result after a set delay
// Assumes: read is a one-cycle pulse on the system clock
// Notes: a delay of 0 reads at the second edge after ready falls
`timescale 1ns/100ps
module acs_host_model
(
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // device side
    input wire logic result_ready_n,
    output logic result_read,
    // behaviour
    input wire logic [7:0] read_delay
);
    logic [7:0] wait_reg;
    logic pend_reg;
    // one read per falling of ready, never a second before it rises
    always_ff @(posedge clock)
    begin
        result_read <= 1'b0;
        if (rst)
            pend_reg <= 1'b0;
        else if (!pend_reg && !result_ready_n && !result_read)
        begin
            pend_reg <= 1'b1;
            wait_reg <= read_delay;
        end
        else if (pend_reg && wait_reg == 8'h00)
        begin
            result_read <= 1'b1;
            pend_reg <= 1'b0;
        end
        else if (pend_reg)
            wait_reg <= wait_reg - 8'h01;
    end
endmodule

// [verif/tb_adc_conversion_sequencer.sv]
// Purpose: self-checking bench of the conversion sequencer
// Assumes: turbo single shot at the fastest rate fits the run length
// Notes: continuous timing needs two long periods, too long for one run
`timescale 1ns/100ps
module tb_adc_conversion_sequencer;
    import acs_pkg::*;
    localparam int T_SINGLE = 65002; // 1065 turbo periods in 8 ns cycles
    localparam int LIMIT = 110000;
    typedef struct {logic [13:0] exc; logic [2:0] fe; logic [3:0] gn;
        logic mon;} acs_note_t;
    logic clock, rst, start_cmd, sleep_cmd, result_read, continuous_mode;
    logic turbo_mode, burnout_enable, amp_bypass, result_ready_n;
    logic conversion_done, converting, sleeping, mod_clock_tick;
    logic filter_restart, excitation_bias_en, excitation_one_en;
    logic excitation_two_en, burnout_source_en, burnout_sink_en;
    logic amp_bypassed, internal_ref_en, supply_monitor_en, refin_monitor_en;
    logic [1:0] reference_select;
    acs_rate_t rate_select, filter_rate;
    acs_field3_t excitation_magnitude, excitation_one_route;
    acs_field3_t excitation_two_route, gain_select, excitation_level;
    acs_field3_t excitation_one_pin, excitation_two_pin, effective_gain;
    acs_sel_t input_selector;
    logic [7:0] read_delay;
    logic [13:0] exc_seen;
    logic rdy_prev, asleep, count_on;
    int cyc, t_latch, ticks, restarts, dones, seed, rnd, bad_count, n_tests;
    acs_note_t note_q[$];
    int time_q[$];
    event cfg_ev;
    assign exc_seen = {excitation_bias_en, excitation_level,
        excitation_one_en, excitation_one_pin, excitation_two_en,
        excitation_two_pin,
        burnout_source_en, burnout_sink_en};

    acs_sequencer acs_sequencer_i (.*);
    acs_host_model acs_host_model_i (.clock(clock), .rst(rst),
        .result_ready_n(result_ready_n), .result_read(result_read),
        .read_delay(read_delay));

    task automatic final_report();
        $display("comparisons %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic compare_val(input string what, input logic [15:0] exp,
                               input logic [15:0] seen);
        n_tests++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic compare_time(input string what, input int exp,
                                input int seen, input int tol);
        n_tests++;
        if (seen > exp + tol || seen + tol < exp)
        begin
            bad_count++;
            $display("BAD %s expected %0d seen %0d", what, exp, seen);
        end
    endtask

    // drive one configuration and note what the outputs must become
    task automatic cfg(input logic [2:0] m, r1, r2, g, input logic b, byp,
                       input logic [3:0] s, input logic [1:0] rf);
        acs_note_t n;
        logic on;
        @(posedge clock);
        excitation_magnitude <= m;
        excitation_one_route <= r1;
        excitation_two_route <= r2;
        burnout_enable <= b;
        input_selector <= s;
        gain_select <= g;
        amp_bypass <= byp;
        reference_select <= rf;
        on = m != 3'h0 && !asleep;
        n.mon = s == 4'hC || s == 4'hD;
        n.exc = {on, m, on && r1 != 3'h0, r1, on && r2 != 3'h0, r2,
            b && !asleep, b && !asleep};
        n.fe = {s == 4'hD, s == 4'hC, n.mon || rf == 2'h0};
        n.gn = n.mon ? 4'h8 : {byp, g};
        note_q.push_back(n);
        repeat (2) @(posedge clock);
        #1;
        -> cfg_ev;
    endtask

    task automatic pulse_start();
        @(posedge clock);
        start_cmd <= 1'b1;
        t_latch = cyc + 1;
        @(posedge clock);
        start_cmd <= 1'b0;
    endtask

    always #4 clock = ~clock;

    always @(cfg_ev)
    begin
        acs_note_t n;
        n = note_q.pop_front();
        compare_val("excitation",
            16'(n.exc[13:2]), 16'(exc_seen[13:2]));
        compare_val("burnout", 16'(n.exc[1:0]), 16'(exc_seen[1:0]));
        compare_val("front end", 16'(n.fe), 16'({supply_monitor_en,
            refin_monitor_en, internal_ref_en}));
        compare_val("gain",
            16'(n.gn), 16'({amp_bypassed, effective_gain}));
    end

    always @(posedge clock)
    begin
        int exp_t;
        cyc <= cyc + 1;
        rdy_prev <= result_ready_n;
        if (mod_clock_tick === 1'b1 && count_on)
            ticks++;
        if (filter_restart === 1'b1)
            restarts++;
        if (conversion_done === 1'b1)
            dones++;
        if (rdy_prev === 1'b1 && result_ready_n === 1'b0)
        begin
            exp_t = (time_q.size() > 0) ? time_q.pop_front() : 0;
            compare_time("conversion time",
                exp_t, cyc - t_latch, 64);
        end
        if (cyc == LIMIT)
        begin
            bad_count++;
            final_report();
        end
    end

    initial
    begin
        {clock, start_cmd, sleep_cmd, continuous_mode, turbo_mode} = 5'h00;
        {burnout_enable, amp_bypass, count_on, asleep} = 4'h0;
        {rate_select, excitation_magnitude, gain_select} = 9'h000;
        {excitation_one_route, excitation_two_route} = 6'h00;
        {input_selector, reference_select} = 6'h00;
        {cyc, ticks, restarts, dones, bad_count, n_tests} = 0;
        rst = 1'b1;
        rdy_prev = 1'b1;
        read_delay = 8'h05;
        seed = 23487;
        repeat (8) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        #1;
        compare_val("ready at reset", 16'h0001, 16'(result_ready_n));
        cfg(3'h3, 3'h1, 3'h1, 3'h7, 1'b1, 1'b0, 4'hD, 2'h1);
        @(posedge clock);
        sleep_cmd <= 1'b1;
        asleep = 1'b1;
        @(posedge clock);
        sleep_cmd <= 1'b0;
        cfg(3'h3, 3'h1, 3'h2, 3'h5, 1'b1, 1'b0, 4'hC, 2'h2);
        compare_val("sleeping", 16'h0001, 16'(sleeping));
        turbo_mode <= 1'b1;
        rate_select <= 3'h6;
        // continuous start-up delay runs out; the first period is cut short by the single shot below
        continuous_mode <= 1'b1;
        pulse_start();
        asleep = 1'b0;
        repeat (30)
        begin
            rnd = $random(seed);
            cfg(rnd[2:0], rnd[5:3], rnd[8:6], rnd[11:9], rnd[12], rnd[13],
                rnd[17:14], rnd[19:18]);
        end
        // magnitude first, start-up wait, then routing
        cfg(3'h5, 3'h0, 3'h0, 3'h2, 1'b0, 1'b1, 4'h3, 2'h1);
        repeat (25000) @(posedge clock);
        cfg(3'h5, 3'h2, 3'h6, 3'h2, 1'b0, 1'b1, 4'h3, 2'h1);
        continuous_mode <= 1'b0;
        pulse_start();
        time_q.push_back(T_SINGLE);
        ticks = 0;
        count_on = 1'b1;
        repeat (12500) @(posedge clock);
        count_on = 1'b0;
        compare_time("modulator ticks", 51, ticks, 2);
        compare_val("converting", 16'h0001, 16'(converting));
        compare_val("filter rate", 16'h0006, 16'(filter_rate));
        for (int i = 0; i < 60000 && converting === 1'b1; i++)
            @(posedge clock);
        repeat (12) @(posedge clock);
        #1;
        compare_val("ready after read",
            16'h0001, 16'(result_ready_n));
        compare_val("bias between shots",
            16'h0001, 16'(excitation_bias_en));
        compare_val("filter restarts", 16'h0002, 16'(restarts));
        compare_val("completions", 16'h0001, 16'(dones));
        compare_val("results left", 16'h0000, 16'(time_q.size()));
        final_report();
    end
endmodule
